// ===== logic/sscs_top.sv
// sscs_top: speed reference selection, torque-mode speed limit, loop gain settings.
// assumes a parameter port on the same clock and an analog reference already in 0.1 r/min.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - select contacts read 0 when off, 1 when on
// - code 00 in a zero-default mode gives a reference of exactly zero
// - code 00 in analog mode passes the analog reference through
// - codes 01, 10, 11 pick internal speed one, two, three
// - internal reference is taken only when a select input changes
// - internal speeds are signed, within plus/minus 50000, 0.1 r/min per count
// - torque modes route the reference to the speed limit instead
// - manual tuning uses only the gains written by the user
// - auto tuning derives gains from inertia and one of ten bandwidth levels
// - position gain is 16-bit, 0 to 2047, reset 35
// - feed-forward gain is 16-bit percent, 0 to 100, reset 50
module sscs_top
  import sscs_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic speed_select_low_i,
  input wire logic speed_select_high_i,
  input wire logic signed [16:0] analog_ref_i,
  input wire logic [7:0] inertia_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [11:0] param_addr_i,
  input wire logic [31:0] param_wdata_i,
  output logic [31:0] param_rdata_o,
  output logic param_rvalid_o,
  output logic signed [16:0] speed_target_o,
  output logic signed [16:0] speed_limit_o,
  output logic limit_active_o,
  output sscs_gain_type gains_o,
  output logic auto_tune_o,
  output logic [3:0] bandwidth_o,
  output logic period_tick_o
);
  logic [1:0] code;
  logic sel_change;
  logic [7:0] cnt_r;
  logic tick;
  logic [15:0] kpp_r;
  logic [15:0] pfg_r;
  logic [15:0] kvp_r;
  logic auto_r;
  logic [3:0] bw_r;
  sscs_mode_type mode_r;
  logic signed [16:0] spd_r [3];
  logic signed [16:0] int_ref_r;
  logic signed [16:0] sel_ref_r;
  logic signed [16:0] target_r;
  logic signed [16:0] limit_r;
  logic limit_act_r;
  sscs_gain_type gains_r;
  logic [31:0] rdata_r;
  logic rvalid_r;

  function automatic logic spd_ok(input logic [31:0] v);
    return ($signed(v) >= SPD_MIN) && ($signed(v) <= SPD_MAX);
  endfunction

  sscs_din_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .din_i({speed_select_high_i, speed_select_low_i}),
    .level_o(code),
    .change_o(sel_change)
  );

  // control period divider
  assign tick = (cnt_r == 8'(CTRL_CYCLES - 1));
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
    end
  end

  // parameter decode; out-of-range writes are dropped, old value kept
  wire wr_kpp = param_wr_i && (param_addr_i == ADDR_KPP) && (param_wdata_i <= 32'(KPP_MAX));
  wire wr_pfg = param_wr_i && (param_addr_i == ADDR_PFG) && (param_wdata_i <= 32'(PFG_MAX));
  wire wr_kvp = param_wr_i && (param_addr_i == ADDR_KVP) && (param_wdata_i[31:16] == 16'h0000);
  wire [3:0] wr_bw = param_wdata_i[TUNE_BW_LSB +: 4];
  wire wr_tune = param_wr_i && (param_addr_i == ADDR_TUNE) && (wr_bw >= BW_MIN)
    && (wr_bw <= BW_MAX);
  wire wr_mode = param_wr_i && (param_addr_i == ADDR_MODE);
  wire [2:0] wr_spd;
  assign wr_spd[0] = param_wr_i && (param_addr_i == ADDR_SPD_ONE) && spd_ok(param_wdata_i);
  assign wr_spd[1] = param_wr_i && (param_addr_i == ADDR_SPD_TWO) && spd_ok(param_wdata_i);
  assign wr_spd[2] = param_wr_i && (param_addr_i == ADDR_SPD_THREE) && spd_ok(param_wdata_i);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      kpp_r <= KPP_RESET;
      pfg_r <= PFG_RESET;
      kvp_r <= KVP_RESET;
      auto_r <= 1'b0;
      bw_r <= BW_RESET;
      mode_r <= MODE_S;
    end else begin
      if (wr_kpp) kpp_r <= param_wdata_i[15:0];
      if (wr_pfg) pfg_r <= param_wdata_i[15:0];
      if (wr_kvp) kvp_r <= param_wdata_i[15:0];
      if (wr_tune) begin
        auto_r <= param_wdata_i[TUNE_AUTO_BIT];
        bw_r <= wr_bw;
      end
      if (wr_mode) mode_r <= sscs_mode_type'(param_wdata_i[1:0]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_spd
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          spd_r[g] <= 17'sh00000;
        end else if (wr_spd[g]) begin
          spd_r[g] <= param_wdata_i[16:0];
        end
      end
    end
  endgenerate

  wire zero_mode = (mode_r == MODE_SZ) || (mode_r == MODE_TZ);
  wire torque_mode = (mode_r == MODE_T) || (mode_r == MODE_TZ);
  wire signed [16:0] int_pick = spd_r[code - 2'd1];
  wire signed [16:0] ref_nxt = (code != 2'b00) ? int_ref_r :
    (zero_mode ? 17'sh00000 : analog_ref_i);

  // auto gains scale with level and inertia; kpp kept at a quarter of kvp
  wire [19:0] bw_prod = {16'h0000, bw_r} * {4'h0, KVP_STEP};
  wire [27:0] scaled = {8'h00, bw_prod} * {20'h00000, inertia_i};
  wire [15:0] kvp_auto = (|scaled[27:22]) ? 16'hFFFF : scaled[21:6];
  // position loop held at a quarter of the speed loop
  wire [15:0] kpp_auto = {2'b00, kvp_auto[15:2]};
  wire [15:0] kpp_auto_lim = (kpp_auto > KPP_MAX) ? KPP_MAX : kpp_auto;
  wire sscs_gain_type gains_nxt = auto_r
    ? sscs_gain_type'{position_proportional_gain: kpp_auto_lim, position_feedforward_gain: pfg_r, velocity_proportional_gain: kvp_auto}
    : sscs_gain_type'{position_proportional_gain: kpp_r, position_feedforward_gain: pfg_r, velocity_proportional_gain: kvp_r};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_ref_r <= 17'sh00000;
      sel_ref_r <= 17'sh00000;
      target_r <= 17'sh00000;
      limit_r <= 17'sh00000;
      limit_act_r <= 1'b0;
      gains_r <= '{position_proportional_gain: KPP_RESET, position_feedforward_gain: PFG_RESET, velocity_proportional_gain: KVP_RESET};
    end else begin
      // taken only on a select change
      if (sel_change && (code != 2'b00)) int_ref_r <= int_pick;
      if (tick) begin
        sel_ref_r <= ref_nxt;
        target_r <= torque_mode ? 17'sh00000 : ref_nxt;
        limit_r <= torque_mode ? ref_nxt : 17'sh00000;
        limit_act_r <= torque_mode;
        gains_r <= gains_nxt;
      end
    end
  end

  // read path, one cycle latency, unmapped reads zero
  wire [31:0] rd_mux =
    (param_addr_i == ADDR_KPP) ? {16'h0000, kpp_r} :
    (param_addr_i == ADDR_PFG) ? {16'h0000, pfg_r} :
    (param_addr_i == ADDR_KVP) ? {16'h0000, kvp_r} :
    (param_addr_i == ADDR_TUNE) ? {24'h000000, bw_r, 3'b000, auto_r} :
    (param_addr_i == ADDR_MODE) ? {30'h00000000, mode_r} :
    (param_addr_i == ADDR_SPD_ONE) ? 32'(spd_r[0]) :
    (param_addr_i == ADDR_SPD_TWO) ? 32'(spd_r[1]) :
    (param_addr_i == ADDR_SPD_THREE) ? 32'(spd_r[2]) :
    (param_addr_i == ADDR_STATUS) ? {13'h0000, code, sel_ref_r} : 32'h00000000;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= param_rd_i;
      if (param_rd_i) rdata_r <= rd_mux;
    end
  end

  assign param_rdata_o = rdata_r;
  assign param_rvalid_o = rvalid_r;
  assign speed_target_o = target_r;
  assign speed_limit_o = limit_r;
  assign limit_active_o = limit_act_r;
  assign gains_o = gains_r;
  assign auto_tune_o = auto_r;
  assign bandwidth_o = bw_r;
  assign period_tick_o = tick;

  // checks
  sequence s_pick_one;
    sel_change && (code == 2'b01) ##1 1'b1;
  endsequence

  a_zero_default_ref: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick && (code == 2'b00) && zero_mode |=> (sel_ref_r == 17'sh00000))
    else $error("zero-default mode gave a nonzero reference");
  a_analog_pass_through: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick && (code == 2'b00) && !zero_mode |=> (sel_ref_r == $past(analog_ref_i)))
    else $error("analog reference not passed");
  a_internal_one_pick: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_pick_one |-> (int_ref_r == $past(spd_r[0], 2)) || $past(wr_spd[0], 2))
    else $error("code 01 did not pick speed one");
  a_hold_without_change: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !sel_change |=> $stable(int_ref_r))
    else $error("internal reference moved without a select change");
  a_speed_in_range: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($signed(32'(spd_r[1])) <= SPD_MAX) && ($signed(32'(spd_r[1])) >= SPD_MIN))
    else $error("internal speed two out of range");
  a_torque_limit_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick && torque_mode |=> limit_act_r && (target_r == 17'sh00000)
      && (limit_r == $past(ref_nxt)))
    else $error("torque mode did not route reference to limit");
  a_manual_gain_use: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick && !auto_r |=> (gains_r.position_proportional_gain == $past(kpp_r)) && (gains_r.velocity_proportional_gain == $past(kvp_r)))
    else $error("manual tuning did not use user gains");
  a_auto_bw_level: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (bw_r >= BW_MIN) && (bw_r <= BW_MAX))
    else $error("bandwidth level outside one to ten");
  a_kpp_limit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (kpp_r <= KPP_MAX) && (gains_r.position_proportional_gain <= KPP_MAX))
    else $error("position gain above limit");
  a_pfg_limit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pfg_r <= PFG_MAX)
    else $error("feed-forward gain above limit");
  a_period_spacing: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick |=> !tick ##249 tick)
    else $error("control period tick spacing wrong");
endmodule
`default_nettype wire

// ===== logic/sscs_pkg.sv
// sscs_pkg: constants, types and parameter map of the speed command selector.
// assumes one 250 MHz clock; parameter port addresses are 12-bit word addresses.
package sscs_pkg;
  // parameter port addresses
  localparam logic [11:0] ADDR_KPP = 12'h200;
  localparam logic [11:0] ADDR_PFG = 12'h202;
  localparam logic [11:0] ADDR_KVP = 12'h204;
  localparam logic [11:0] ADDR_TUNE = 12'h206;
  localparam logic [11:0] ADDR_SPD_ONE = 12'h110;
  localparam logic [11:0] ADDR_SPD_TWO = 12'h112;
  localparam logic [11:0] ADDR_SPD_THREE = 12'h114;
  localparam logic [11:0] ADDR_MODE = 12'h116;
  localparam logic [11:0] ADDR_STATUS = 12'h118;
  // reset values and limits
  localparam logic [15:0] KPP_RESET = 16'h0023;
  localparam logic [15:0] KPP_MAX = 16'h07FF;
  localparam logic [15:0] PFG_RESET = 16'h0032;
  localparam logic [15:0] PFG_MAX = 16'h0064;
  localparam logic [15:0] KVP_RESET = 16'h00C8;
  localparam logic signed [31:0] SPD_MAX = 32'sh0000C350;
  localparam logic signed [31:0] SPD_MIN = -32'sh0000C350;
  localparam logic [3:0] BW_MIN = 4'h1;
  localparam logic [3:0] BW_MAX = 4'hA;
  localparam logic [3:0] BW_RESET = 4'h5;
  localparam logic [15:0] KVP_STEP = 16'h0028;
  // tune register fields
  localparam int TUNE_AUTO_BIT = 0;
  localparam int TUNE_BW_LSB = 4;
  // control period
  localparam int CLK_PERIOD_NS = 4;
  localparam int CTRL_PERIOD_NS = 1000;
  localparam int CTRL_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_S,
    MODE_SZ,
    MODE_T,
    MODE_TZ
  } sscs_mode_type;

  typedef struct packed {
    logic [15:0] position_proportional_gain;
    logic [15:0] position_feedforward_gain;
    logic [15:0] velocity_proportional_gain;
  } sscs_gain_type;
endpackage

// ===== logic/sscs_din_sync.sv
// sscs_din_sync: three-stage synchroniser with agreement filter for select inputs.
// assumes asynchronous contact inputs, high meaning contact on.
`timescale 1ns/1ps
`default_nettype none
module sscs_din_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] din_i,
  output logic [1:0] level_o,
  output logic change_o
);
  logic [1:0] upd;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= din_i[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign upd[g] = (s2_r == s3_r) && (s3_r != lvl_r);
      assign level_o[g] = lvl_r;
    end
  endgenerate

  // pulse lines up with the new level
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      change_o <= 1'b0;
    end else begin
      change_o <= |upd;
    end
  end
endmodule
`default_nettype wire

// ===== tb/sscs_ctrl_model.sv
// sscs_ctrl_model: outside motion controller driving the two select contacts.
// assumes the bench hands it a code; contacts change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module sscs_ctrl_model (
  input wire logic clk_i,
  input wire logic [1:0] code_i,
  output logic speed_select_low_o,
  output logic speed_select_high_o
);
  initial begin
    speed_select_low_o = 1'b0;
    speed_select_high_o = 1'b0;
  end
  always @(posedge clk_i) begin
    speed_select_low_o <= code_i[0];
    speed_select_high_o <= code_i[1];
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench of the speed command selector.
// assumes the select contacts come from the controller model only.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, exp, got); \
  end
module tb_top
  import sscs_pkg::*;
;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} sscs_row_type;
  logic clk_i = 1'b0, nrst_i = 1'b0, param_wr_i = 1'b0, param_rd_i = 1'b0;
  logic [1:0] code = 2'h0;
  logic speed_select_low_i, speed_select_high_i, param_rvalid_o, limit_active_o;
  logic signed [16:0] analog_ref_i = 17'sh00309, speed_target_o, speed_limit_o;
  logic [7:0] inertia_i = 8'h40;
  logic [11:0] param_addr_i = 12'h000;
  logic [31:0] param_wdata_i = 32'h0, param_rdata_o;
  sscs_gain_type gains_o;
  logic auto_tune_o, period_tick_o;
  logic [3:0] bandwidth_o;
  int n_errors = 0, check_count = 0, n;
  sscs_row_type rows [11] = '{
    '{1'b0, ADDR_KPP, 32'h0, 32'h23}, '{1'b0, ADDR_PFG, 32'h0, 32'h32},
    '{1'b1, ADDR_KPP, 32'h7FF, 32'h7FF}, '{1'b1, ADDR_KPP, 32'h800, 32'h7FF},
    '{1'b1, ADDR_PFG, 32'h64, 32'h64}, '{1'b1, ADDR_PFG, 32'h65, 32'h64},
    '{1'b1, ADDR_SPD_ONE, 32'hC350, 32'hC350}, '{1'b1, ADDR_SPD_ONE, 32'hC351, 32'hC350},
    '{1'b1, ADDR_SPD_TWO, 32'hFFFF3CB0, 32'hFFFF3CB0}, '{1'b1, 12'h3FE, 32'h5, 32'h0},
    '{1'b1, ADDR_TUNE, 32'hB1, 32'h50}};
  always #2 clk_i = ~clk_i;
  sscs_ctrl_model sscs_ctrl_model_i (.clk_i, .code_i(code),
    .speed_select_low_o(speed_select_low_i), .speed_select_high_o(speed_select_high_i));
  sscs_top sscs_top_i (.clk_i, .nrst_i, .speed_select_low_i, .speed_select_high_i,
    .analog_ref_i, .inertia_i, .param_wr_i, .param_rd_i, .param_addr_i, .param_wdata_i,
    .param_rdata_o, .param_rvalid_o, .speed_target_o, .speed_limit_o, .limit_active_o,
    .gains_o, .auto_tune_o, .bandwidth_o, .period_tick_o);
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    param_wr_i <= 1'b1;
    param_addr_i <= a;
    param_wdata_i <= d;
    @(posedge clk_i);
    param_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    param_rd_i <= 1'b1;
    param_addr_i <= a;
    @(posedge clk_i);
    param_rd_i <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, param_rvalid_o)
    d = param_rdata_o;
  endtask
  // waits for the tick edge, then lets the outputs land
  task automatic wait_tick(output int k);
    for (k = 0; k < 300 && period_tick_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (k == 300) begin
      n_errors++;
      wrap_up();
    end
    @(posedge clk_i);
    #1;
  endtask
  task automatic sel(input logic [1:0] c);
    code <= c;
    repeat (8) @(posedge clk_i);
    #1;
    wait_tick(n);
  endtask
  initial begin
    logic [31:0] d;
    repeat (4) @(posedge clk_i);
    `CHK("rst target", 17'sh0, speed_target_o)
    `CHK("rst bw", BW_RESET, bandwidth_o)
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      `CHK("reg row", rows[i].e, d)
    end
    wr(ADDR_SPD_THREE, 32'h4D2);
    wr(ADDR_KPP, 32'h64);
    // keep velocity gain at four times the position gain
    wr(ADDR_KVP, 32'h190);
    sel(2'b00);
    `CHK("analog", analog_ref_i, speed_target_o)
    wait_tick(n);
    `CHK("period", CTRL_CYCLES, n + 1)
    sel(2'b01);
    `CHK("spd one", 17'sh0C350, speed_target_o)
    sel(2'b10);
    `CHK("spd two", -17'sh0C350, speed_target_o)
    sel(2'b11);
    `CHK("spd three", 17'sh004D2, speed_target_o)
    wr(ADDR_SPD_THREE, 32'h7);
    wait_tick(n);
    `CHK("no change", 17'sh004D2, speed_target_o)
    wr(ADDR_MODE, 32'(MODE_T));
    sel(2'b01);
    `CHK("limit", 17'sh0C350, speed_limit_o)
    `CHK("target t", 17'sh0, speed_target_o)
    `CHK("limit on", 1'b1, limit_active_o)
    wr(ADDR_MODE, 32'(MODE_SZ));
    sel(2'b00);
    `CHK("zero", 17'sh0, speed_target_o)
    `CHK("man kpp", 16'h0064, gains_o.position_proportional_gain)
    `CHK("man kvp", 16'h0190, gains_o.velocity_proportional_gain)
    wr(ADDR_MODE, 32'(MODE_TZ));
    wait_tick(n);
    `CHK("tz limit", 17'sh0, speed_limit_o)
    `CHK("tz on", 1'b1, limit_active_o)
    wr(ADDR_MODE, 32'(MODE_T));
    wait_tick(n);
    `CHK("t analog", analog_ref_i, speed_limit_o)
    rd(ADDR_STATUS, d);
    `CHK("status", 32'h00000309, d)
    // manual pair kept at four to one before switching to auto
    wr(ADDR_KPP, 32'h2);
    wr(ADDR_KVP, 32'h8);
    wr(ADDR_TUNE, 32'hA1);
    wait_tick(n);
    `CHK("auto", 1'b1, auto_tune_o)
    `CHK("auto bw", 4'hA, bandwidth_o)
    `CHK("auto kvp", 16'h0190, gains_o.velocity_proportional_gain)
    `CHK("auto kpp", 16'h0064, gains_o.position_proportional_gain)
    `CHK("auto pfg", 16'h0064, gains_o.position_feedforward_gain)
    wrap_up();
  end
endmodule
`default_nettype wire
